/* File: core/sztp_pkg.sv */
package sztp_pkg;
    // array shape: 256K words of 36 bits, four 9-bit byte lanes
    localparam int ADDR_W = 18;
    localparam int LANE_W = 9;
    localparam int LANE_N = 4;
    localparam int DATA_W = 36;
    localparam int DEPTH  = 262144;

    // burst counter reset value and step
    localparam logic [1:0] CNT_RST  = 2'h0;
    localparam logic [1:0] CNT_STEP = 2'h1;

    typedef logic [ADDR_W-1:0] sztp_addr_t;

    // one data word split into byte lanes, lane a in the low bits
    typedef struct packed {
        logic [LANE_W-1:0] d;
        logic [LANE_W-1:0] c;
        logic [LANE_W-1:0] b;
        logic [LANE_W-1:0] a;
    } sztp_lanes_t;

    // whole state of the port
    typedef struct packed {
        logic              active;  // current burst is selected
        logic              isWrite; // cycle type fixed at load
        sztp_addr_t        base;    // loaded address
        logic [1:0]        seed;    // loaded low bits
        logic [1:0]        cnt;     // beats since load
        logic              drive;   // read data valid this cycle
        logic              wrPend;  // write data due at next edge
        sztp_addr_t        wrAddr;  // address of that write
        logic [LANE_N-1:0] wrLane;  // lanes enabled for that write
    } sztp_state_t;

    localparam sztp_state_t STATE_RST = '0;
endpackage

/* File: core/sztp_mem.sv */
`timescale 1ns/1ps
// storage array with registered read data and same-edge write bypass
module sztp_mem
    import sztp_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // read port
    input  wire logic              rdEn,
    input  wire sztp_addr_t        rdAddr,
    output sztp_lanes_t            rdData,
    // write port
    input  wire logic              wrEn,
    input  wire sztp_addr_t        wrAddr,
    input  wire sztp_lanes_t       wrData,
    input  wire logic [LANE_N-1:0] wrLane
);
    logic [DATA_W-1:0] store [DEPTH];  // the array, no reset
    logic [DATA_W-1:0] rdData_q;       // read data register
    logic              hit;            // read and write meet on one word

    assign hit    = wrEn && (wrAddr == rdAddr);
    assign rdData = sztp_lanes_t'(rdData_q);

    // per-lane write, and read that returns fresh data on a collision
    // so a read right behind a write needs no idle cycle
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < LANE_N; i++) begin
            if (wrEn && wrLane[i]) begin
                store[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
            end
        end
        if (!reset_n) begin
            rdData_q <= '0;
        end else if (rdEn) begin
            for (int i = 0; i < LANE_N; i++) begin
                rdData_q[i*LANE_W +: LANE_W] <= (hit && wrLane[i])
                    ? wrData[i*LANE_W +: LANE_W] : store[rdAddr][i*LANE_W +: LANE_W];
            end
        end
    end
endmodule // sztp_mem

/* File: core/sztp_port.sv */
`timescale 1ns/1ps
// Function
// - capture all synchronous inputs on rising clock
// - reads and writes alternate with no idle
// - two-bit burst counter seeded from low address
// - advance-or-load low loads a new address
// - advance-or-load high steps burst, ignores read/write
// - cycle type fixed only on load cycles
// - writes happen on the clock, self-timed
// - each active-low lane enable gates its lane
// - selects sampled on loads, all three needed
// - clock gate high holds all state
// - output enable turns drivers asynchronously
// - burst order selectable, linear or interleaved
// - array is 256K words of 36 bits
// - order select low linear, high interleaved
// - sleep high holds contents, ignores inputs
// - full-word write when all lanes enabled
module sztp_port
    import sztp_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // address and cycle control
    input  wire sztp_addr_t  address,        // low two bits seed bursts
    input  wire logic        advanceOrLoad,
    input  wire logic        readNotWrite,   // high read, low write
    input  wire logic        chipSelect_n,
    input  wire logic        expansionSelect_n,
    input  wire logic        expansionSelect,
    input  wire logic        laneAWrite_n,
    input  wire logic        laneBWrite_n,
    input  wire logic        laneCWrite_n,
    input  wire logic        laneDWrite_n,
    // static and asynchronous controls
    input  wire logic        clockGate_n,    // high suspends the clock
    input  wire logic        burstInterleave,// low linear, high interleaved
    input  wire logic        outputEnable_n,
    input  wire logic        sleepRequest,
    // data lanes, split into in, out and enable
    input  wire sztp_lanes_t dataLaneIn,
    output sztp_lanes_t      dataLaneOut,
    output logic [LANE_N-1:0] dataLaneOe
);
    sztp_state_t       st_q;       // registered state
    sztp_state_t       st_d;       // next state
    logic              go;         // this edge acts on the port
    logic              loadSel;    // all three selects asserted
    logic [1:0]        stepCnt;    // counter after one step
    sztp_addr_t        cycAddr;    // word addressed this cycle
    logic              memRdEn;    // launch an array read
    logic              memWe;      // commit the pending write
    logic [LANE_N-1:0] laneWrite;  // lane enables, active high
    logic [DATA_W-1:0] wrMask;     // pending lanes, one bit per data bit

    // low address bits for a beat; interleave xors, linear adds
    function automatic logic [1:0] burstLow(input logic [1:0] seed,
                                            input logic [1:0] cnt,
                                            input logic       ilv);
        burstLow = ilv ? (seed ^ cnt) : 2'(seed + cnt);
    endfunction

    // an edge only counts with reset released, clock ungated and awake
    assign go        = reset_n && !clockGate_n && !sleepRequest;
    assign loadSel   = !chipSelect_n && !expansionSelect_n && expansionSelect;
    assign laneWrite = ~{laneDWrite_n, laneCWrite_n, laneBWrite_n, laneAWrite_n};
    assign stepCnt   = 2'(st_q.cnt + CNT_STEP);

    // next-state logic: load, advance, and write data one beat behind its address
    always_comb begin
        st_d    = st_q;
        cycAddr = address;
        memRdEn = 1'b0;
        memWe   = 1'b0;
        if (go) begin
            // data for the previous write beat is on the lanes now
            memWe       = st_q.wrPend;
            st_d.wrPend = 1'b0;
            if (!advanceOrLoad) begin
                // load: selects and cycle type only looked at here
                st_d.active  = loadSel;
                st_d.isWrite = !readNotWrite;
                st_d.base    = address;
                st_d.seed    = address[1:0];
                st_d.cnt     = CNT_RST;
                cycAddr      = address;
            end else begin
                // advance: read/write pin ignored, type inherited
                st_d.cnt = stepCnt;
                cycAddr  = {st_q.base[ADDR_W-1:2],
                            burstLow(st_q.seed, stepCnt, burstInterleave)};
            end
            // read beats fetch now; deselected beats do nothing
            st_d.drive = st_d.active && !st_d.isWrite;
            memRdEn    = st_d.drive;
            if (st_d.active && st_d.isWrite) begin
                // lane enables tied to this beat's address
                st_d.wrPend = 1'b1;
                st_d.wrAddr = cycAddr;
                st_d.wrLane = laneWrite;
            end
        end
        // reset last, so it overrides whatever the edge would have done
        if (!reset_n) begin
            st_d = STATE_RST;
        end
    end

    // single state register
    always_ff @(posedge clk_sys) begin
        st_q <= st_d;
    end

    // the array, 256K x 36 in four lanes; its contents are never cleared,
    // so a word read before any write comes back unknown
    sztp_mem u_mem (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .rdEn    (memRdEn),
        .rdAddr  (cycAddr),
        .rdData  (dataLaneOut),
        .wrEn    (memWe),
        .wrAddr  (st_q.wrAddr),
        .wrData  (dataLaneIn),
        .wrLane  (st_q.wrLane)
    );

    // widen the pending lane enables to one bit per data bit for the checks below
    for (genvar g = 0; g < LANE_N; g++) begin : g_mask
        assign wrMask[g*LANE_W +: LANE_W] = {LANE_W{st_q.wrLane[g]}};
    end

    // drivers follow the enable pin with no clock in the path,
    // so this output alone is not from a flip-flop;
    // sleep darkens the lanes too, so a sleeping port never fights the bus
    assign dataLaneOe = {LANE_N{st_q.drive && !outputEnable_n && !sleepRequest}};

    // every check below runs on the port clock and rests during reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // a gated edge must leave every state bit where it was
    a_gate_hold: assert property (clockGate_n |=> $stable(st_q))
        else $error("state moved while clock gated");

    // standby edges are ignored just like gated ones
    a_sleep_hold: assert property (sleepRequest |=> $stable(st_q))
        else $error("state moved while asleep");

    // standby also darkens the lanes, whatever the enable pin says
    a_sleep_dark: assert property (sleepRequest |-> dataLaneOe == 4'h0)
        else $error("lanes driven while asleep");

    // a load restarts the counter from the new low address bits
    a_load_seed: assert property (go && !advanceOrLoad
        |=> st_q.cnt == 2'h0 && st_q.seed == $past(address[1:0]))
        else $error("burst counter not seeded on load");

    // a read load fetches the word on the pins, not a counted one
    a_read_launch: assert property (go && !advanceOrLoad && loadSel && readNotWrite
        |-> memRdEn && cycAddr == address)
        else $error("read load missed its address");

    // a selected write load queues its address and lanes for the next edge
    a_write_lanes: assert property (go && !advanceOrLoad && loadSel && !readNotWrite
        |=> st_q.wrPend && st_q.wrAddr == $past(address)
            && st_q.wrLane == $past(laneWrite))
        else $error("write beat not queued with its lanes");

    // a deselected load neither drives nor queues a write
    a_deselect_idle: assert property (go && !advanceOrLoad && !loadSel
        |=> !st_q.drive && !st_q.wrPend && !memWe)
        else $error("deselected cycle acted");

    // advances after a deselected load stay quiet too
    a_deselect_burst: assert property (go && advanceOrLoad && !st_q.active
        |=> !st_q.drive && !st_q.wrPend)
        else $error("deselected burst acted");

    // advances keep the type and select fixed at the load
    a_type_inherit: assert property (go && advanceOrLoad
        |=> st_q.isWrite == $past(st_q.isWrite) && st_q.active == $past(st_q.active))
        else $error("burst changed cycle type");

    // a write burst stays a write even with the read/write pin high
    a_burst_write: assert property (go && advanceOrLoad && st_q.active && st_q.isWrite
        |=> st_q.wrPend && !st_q.drive)
        else $error("write burst turned into a read");

    // only the two low bits move within a burst
    a_burst_upper: assert property (go && advanceOrLoad
        |-> cycAddr[ADDR_W-1:2] == st_q.base[ADDR_W-1:2])
        else $error("burst left its four-word group");

    // linear order counts up from the seed, wrapping at four
    a_linear_step: assert property (go && advanceOrLoad && !burstInterleave
        |-> cycAddr[1:0] == 2'(st_q.seed + st_q.cnt + 2'h1))
        else $error("linear burst address wrong");

    // interleaved order: address bits xor the seed give the beat count
    a_ilv_step: assert property (go && advanceOrLoad && burstInterleave
        |-> (cycAddr[1:0] ^ st_q.seed) == 2'(st_q.cnt + 2'h1))
        else $error("interleaved burst address wrong");

    // the queued write lands at the very next acting edge
    a_write_commit: assert property (go && st_q.wrPend |-> memWe)
        else $error("pending write not committed");

    // a read right behind a write to the same word sees the new lanes
    a_read_bypass: assert property (go && !advanceOrLoad && loadSel && readNotWrite
        && st_q.wrPend && address == st_q.wrAddr
        |=> ((DATA_W'(dataLaneOut) ^ $past(dataLaneIn)) & $past(wrMask)) == '0)
        else $error("read behind write missed new data");

    // a selected read load drives all lanes in the following cycle
    a_read_drive: assert property (go && !advanceOrLoad && loadSel && readNotWrite
        ##1 !outputEnable_n && !sleepRequest |-> dataLaneOe == 4'hf)
        else $error("read beat not driven");
endmodule // sztp_port

/* File: test/sztp_ctrl_model.sv */
`timescale 1ns/1ps
// controller model: one beat per edge, notes each expected read
module sztp_ctrl_model
    import sztp_pkg::*;
(
    // bus clock
    input wire logic clk_sys
);
    // pins towards the port, idle at time zero
    sztp_addr_t  address = '0;
    logic        advanceOrLoad = 1'b1, readNotWrite = 1'b1, reset_n = 1'b0;
    logic        chipSelect_n = 1'b1, expansionSelect_n = 1'b1, expansionSelect = 1'b0;
    logic        clockGate_n = 1'b0, burstInterleave = 1'b0, outputEnable_n = 1'b0;
    logic        sleepRequest = 1'b0; // low unless standby is the
    logic [3:0]  laneWrite_n = 4'hf;
    sztp_lanes_t dataLaneIn = '0;
    // reference array, expected reads and a mirror of the burst state
    sztp_lanes_t refMem[sztp_addr_t], expQ[$], wDat;
    sztp_addr_t  base, wAddr;
    logic [1:0]  cnt;
    logic [3:0]  wLane;
    logic        sel, isWr, wPend = 1'b0, wentGo = 1'b0;
    // did the port act on the last edge
    always @(posedge clk_sys) wentGo <= reset_n & !clockGate_n & !sleepRequest;
    // one beat; ld high advances, cs is {high, low, low} selects
    task automatic beat(input logic ld, rnw, input sztp_addr_t a,
                        input logic [3:0] wn, input logic [2:0] cs);
        sztp_lanes_t m, e;
        sztp_addr_t  ba;
        logic        rd;
        if (wPend) begin // held write data lands at this edge
            m = refMem.exists(wAddr) ? refMem[wAddr] : '0;
            for (int i = 0; i < 4; i++) if (!wLane[i]) m[i*9 +: 9] = wDat[i*9 +: 9];
            refMem[wAddr] = m;
        end
        // a bus carrying no write data churns rather than holding
        dataLaneIn = wPend ? wDat : 36'({$urandom, $urandom});
        if (!ld) // type and select fixed at load
            {base, cnt, isWr, sel} = {a, 2'h0, !rnw, cs == 3'b100};
        else
            cnt = cnt + 2'h1;
        ba = {base[17:2], burstInterleave ? base[1:0] ^ cnt : base[1:0] + cnt};
        // the read's expectation is noted at its edge, not before it
        rd = sel && !isWr;
        e  = rd ? refMem[ba] : '0;
        {wPend, wAddr, wLane} = {sel && isWr, ba, wn};
        wDat = 36'({$urandom, $urandom});
        // on advances address, type and selects are noise to be ignored
        address = ld ? sztp_addr_t'($urandom) : a;
        readNotWrite = ld ? 1'($urandom) : rnw;
        {expansionSelect, expansionSelect_n, chipSelect_n} = ld ? 3'($urandom) : cs;
        {advanceOrLoad, laneWrite_n} = {ld, wn}; // lanes ride with their address
        @(posedge clk_sys);
        if (rd) expQ.push_back(e); // data stands from this edge until the next
        #2;
    endtask
    // gated or sleeping edges with a junk write load on the pins
    task automatic hold(input logic gate, slp, input int n);
        {clockGate_n, sleepRequest} = {gate, slp};
        {advanceOrLoad, readNotWrite, laneWrite_n} = 6'h0;
        repeat (n) @(posedge clk_sys);
        #2;
        {clockGate_n, sleepRequest} = 2'h0;
    endtask
endmodule // sztp_ctrl_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
// bench top: controller model drives the port, a monitor checks reads
module tb_top;
    import sztp_pkg::*;
    logic              clk_sys = 1'b0;
    int                n_mismatch = 0, checked = 0;
    sztp_lanes_t       dataLaneOut;
    logic [LANE_N-1:0] dataLaneOe;
    sztp_addr_t        a;
    always #12.5 clk_sys = ~clk_sys;
    sztp_ctrl_model ctl (.clk_sys(clk_sys));
    sztp_port dut (.clk_sys(clk_sys), .reset_n(ctl.reset_n), .address(ctl.address),
        .advanceOrLoad(ctl.advanceOrLoad), .readNotWrite(ctl.readNotWrite),
        .chipSelect_n(ctl.chipSelect_n), .expansionSelect_n(ctl.expansionSelect_n),
        .expansionSelect(ctl.expansionSelect), .laneAWrite_n(ctl.laneWrite_n[0]),
        .laneBWrite_n(ctl.laneWrite_n[1]), .laneCWrite_n(ctl.laneWrite_n[2]),
        .laneDWrite_n(ctl.laneWrite_n[3]), .clockGate_n(ctl.clockGate_n),
        .burstInterleave(ctl.burstInterleave), .outputEnable_n(ctl.outputEnable_n),
        .sleepRequest(ctl.sleepRequest), .dataLaneIn(ctl.dataLaneIn),
        .dataLaneOut(dataLaneOut), .dataLaneOe(dataLaneOe));
    // compare tasks, one per kind of result
    task automatic chk_word(input sztp_lanes_t e);
        checked++;
        if (dataLaneOut !== e) n_mismatch++;
        if (dataLaneOut !== e) $display("[ERR] dataLaneOut exp %h got %h", e, dataLaneOut);
    endtask
    task automatic chk_oe(input logic [3:0] e);
        checked++;
        if (dataLaneOe !== e) n_mismatch++;
        if (dataLaneOe !== e) $display("[ERR] dataLaneOe exp %h got %h", e, dataLaneOe);
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // monitor: a read beat shows in the cycle after its edge
    always @(negedge clk_sys) begin
        if (ctl.sleepRequest)
            chk_oe(4'h0);
        else if (ctl.wentGo && ctl.expQ.size() > 0) begin
            chk_oe(4'hf);
            chk_word(ctl.expQ.pop_front());
        end else if (ctl.wentGo)
            chk_oe(4'h0);
    end
    // watchdog, far beyond the sixty or so cycles of stimulus
    initial begin
        #50000;
        n_mismatch++;
        close_out();
    end
    initial begin
        void'($urandom(32'h188e6581));
        repeat (4) @(posedge clk_sys);
        #2;
        ctl.reset_n = 1'b1;
        // full-word burst writes, then reads from two seeds, per order
        for (int m = 0; m < 2; m++) begin
            ctl.burstInterleave = m[0];
            a = sztp_addr_t'($urandom);
            for (int i = 0; i < 4; i++) ctl.beat(i > 0, 1'b0, a, 4'h0, 3'b100);
            for (int i = 0; i < 8; i++)
                ctl.beat(i % 4 > 0, 1'b1, a ^ 18'(i / 4), 4'h0, 3'b100);
        end
        // alternating lane writes and reads on one word, no idle edges
        for (int i = 0; i < 8; i++) ctl.beat(1'b0, i[0], a, 4'($urandom), 3'b100);
        ctl.outputEnable_n = 1'b1;
        #1 chk_oe(4'h0);
        ctl.outputEnable_n = 1'b0;
        #1 chk_oe(4'hf);
        // each select dropped in turn: the write must not land
        for (int k = 0; k < 3; k++) begin
            ctl.beat(1'b0, 1'b0, a, 4'h0, 3'b100 ^ 3'(1 << k));
            ctl.beat(1'b1, 1'b0, a, 4'h0, 3'b100);
            ctl.beat(1'b0, 1'b1, a, 4'hf, 3'b100);
        end
        // suspended edges inside a read burst, then standby after a write load
        ctl.beat(1'b0, 1'b1, a, 4'hf, 3'b100);
        ctl.hold(1'b1, 1'b0, 2);
        for (int i = 0; i < 3; i++) ctl.beat(1'b1, 1'b0, a, 4'h0, 3'b000);
        ctl.beat(1'b0, 1'b0, a, 4'($urandom), 3'b100);
        ctl.hold(1'b0, 1'b1, 3);
        ctl.beat(1'b0, 1'b1, a, 4'hf, 3'b100);
        ctl.beat(1'b1, 1'b0, a, 4'hf, 3'b100);
        @(negedge clk_sys);
        #1;
        close_out();
    end
endmodule // tb_top
